// >>> rtl/tcg_pkg.sv
// package for the memory control and security gate register block
// assumes a 32-bit register port with byte addresses and one processor clock
package tcg_pkg;

  // ************************************************************
  // register byte addresses
  // ************************************************************
  localparam logic [31:0] ADDR_IGATE_CTRL = 32'hE001_E500;
  localparam logic [31:0] ADDR_IGATE_CFG  = 32'hE001_E504;
  localparam logic [31:0] ADDR_IGATE_LUT  = 32'hE001_E510;
  localparam logic [31:0] ADDR_DGATE_CTRL = 32'hE001_E600;
  localparam logic [31:0] ADDR_DGATE_CFG  = 32'hE001_E604;
  localparam logic [31:0] ADDR_DGATE_LUT  = 32'hE001_E610;
  localparam logic [31:0] ADDR_IMEM_CTRL  = 32'hE001_E580;
  localparam logic [31:0] ADDR_DMEM_CTRL  = 32'hE001_E584;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'hE001_E588;
  localparam logic [31:0] ADDR_IRQ_MASK   = 32'hE001_E58C;
  localparam logic [31:0] LUT_SPAN        = 32'h0000_0040;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int MEMCR_EN_BIT     = 0;
  localparam int MEMCR_SZ_LSB     = 3;
  localparam int GCTRL_DFEN_BIT   = 0;
  localparam int GCTRL_SERR_BIT   = 1;
  localparam int GCFG_PRESENT_BIT = 31;
  localparam int GCFG_NB_LSB      = 8;
  localparam int GCFG_BS_LSB      = 0;
  localparam int IRQ_IGATE_BIT    = 0;
  localparam int IRQ_DGATE_BIT    = 1;
  localparam int IRQ_PRIV_BIT     = 2;

  // ************************************************************
  // sizes and bias values
  // ************************************************************
  localparam int BLOCK_SHIFT_BIAS = 5;
  localparam int NUMBLK_BIAS      = 4;
  localparam int LUT_BITS         = 512;
  localparam int LUT_IDX_W        = 9;
  localparam int MEM_ADDR_W       = 24;
  localparam int IRQ_W            = 3;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [1:0]  GCTRL_RST    = 2'h3;
  localparam logic [31:0] LUT_RST      = 32'h0000_0000;
  localparam logic [2:0]  IRQ_MASK_RST = 3'h0;

endpackage : tcg_pkg

// >>> rtl/tcg_top.sv
// memory control and security gate register block: enables, size report, block gates
// assumes a single-cycle register port on sys_clk and pins from the system that need syncing
//
// Contract
// - memory control reports read-only size code in bits 6 to 3
// - cleared enable bit sends software accesses to the main bus port
// - reset loads each enable bit from the initial-enable input
// - enable bit gates only software accesses, slave port always allowed
// - memory control lock input makes both memory control registers read-only
// - secure build without fault banking: memory control is zero-read, write-ignore from non-secure
// - unprivileged register access is refused and raises a bus fault
// - gate control bit 1 enables slave port error on gate fault
// - gate control bit 0 enables data-side bus fault on gate fault
// - gate lock inputs make their gate control and lookup registers read-only
// - gate registers zero-read, write-ignore from non-secure, or in a build without security when the gate is absent
// - gate config bit 31 shows whether the gate exists
// - gate config bits 11 to 8 give size code plus four minus block size
// - gate config bits 3 to 0 give block size code, block is 2^(code+5) bytes
// - sixteen lookup words, bit i of word n guards block 32n plus i
// - lookup bits beyond the implemented block count read zero, ignore writes
// - lookup bit zero marks block secure, one marks it non-secure
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
module tcg_top #(
  parameter bit         SECURITY_PRESENT   = 1'b1,
  parameter bit         INSTR_GATE_PRESENT = 1'b1,
  parameter bit         DATA_GATE_PRESENT  = 1'b1,
  parameter logic [3:0] INSTR_MEM_SIZE     = 4'h6,
  parameter logic [3:0] DATA_MEM_SIZE      = 4'h6,
  parameter logic [3:0] INSTR_BLOCK_SIZE   = 4'h3,
  parameter logic [3:0] DATA_BLOCK_SIZE    = 4'h3
) (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  // register port
  input  wire logic [31:0]                   reg_addr,
  input  wire logic [31:0]                   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic                          reg_privileged,
  input  wire logic                          reg_nonsecure,
  output logic      [31:0]                   reg_rdata,
  output logic                               reg_bus_fault,
  // system pins and processor state
  input  wire logic [1:0]                    initial_mem_enable_in,
  input  wire logic                          mem_ctrl_lock_in,
  input  wire logic                          instr_gate_lock_in,
  input  wire logic                          data_gate_lock_in,
  input  wire logic                          nonsecure_fault_banking,
  // memory accesses, index 0 instruction, 1 data
  input  wire logic [1:0]                    acc_valid,
  input  wire logic [1:0]                    acc_from_slave,
  input  wire logic [1:0]                    acc_nonsecure,
  input  wire logic [tcg_pkg::MEM_ADDR_W-1:0] instr_acc_addr,
  input  wire logic [tcg_pkg::MEM_ADDR_W-1:0] data_acc_addr,
  // access results
  output logic      [1:0]                    route_to_main,
  output logic      [1:0]                    slave_port_error,
  output logic      [1:0]                    data_fault,
  output logic      [1:0]                    mem_enable,
  // interrupt
  output logic                               irq
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic [1:0] init_en_s;
  logic [2:0] lock_s;

  // two flops per pin, bit 0 memory lock, 1 and 2 gate locks, 3 and 4 initial enables
  always_ff @(posedge sys_clk)
  begin
    pin_s1_q <= {initial_mem_enable_in, data_gate_lock_in, instr_gate_lock_in, mem_ctrl_lock_in};
    pin_s2_q <= pin_s1_q;
  end

  assign lock_s    = pin_s2_q[2:0];
  assign init_en_s = pin_s2_q[4:3];

  // ************************************************************
  // shared register port decode
  // ************************************************************
  logic [1:0]  mc_hit;
  logic [1:0]  gate_hit;
  logic [31:0] mc_rdata   [2];
  logic [31:0] gate_rdata [2];
  logic [1:0]  fault_ev;
  logic        st_hit;
  logic        mk_hit;
  logic        any_hit;
  logic        wr_ok;
  logic        priv_fault;
  logic [31:0] rd_mux;

  // register access is only honoured when privileged
  assign st_hit     = (reg_addr == tcg_pkg::ADDR_IRQ_STATUS);
  assign mk_hit     = (reg_addr == tcg_pkg::ADDR_IRQ_MASK);
  assign any_hit    = (|mc_hit) | (|gate_hit) | st_hit | mk_hit;
  assign wr_ok      = reg_wr & reg_privileged;
  assign priv_fault = (reg_wr | reg_rd) & any_hit & ~reg_privileged;

  // ************************************************************
  // interrupt status and mask
  // ************************************************************
  logic [2:0] irq_sts_q;
  logic [2:0] irq_sts_d;
  logic [2:0] irq_mask_q;
  logic [2:0] irq_ev;
  logic [2:0] irq_clr;

  // set wins over a write-one clear in the same cycle
  assign irq_ev    = {priv_fault, fault_ev};
  assign irq_clr   = (wr_ok & st_hit) ? reg_wdata[2:0] : 3'h0;
  assign irq_sts_d = (irq_sts_q & ~irq_clr) | irq_ev;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      irq_sts_q  <= 3'h0;
      irq_mask_q <= tcg_pkg::IRQ_MASK_RST;
      irq        <= 1'b0;
    end
    else
    begin
      irq_sts_q <= irq_sts_d;
      if (wr_ok && mk_hit)
        irq_mask_q <= reg_wdata[2:0];
      irq <= |(irq_sts_q & irq_mask_q);
    end
  end

  // ************************************************************
  // read data and refusal answer
  // ************************************************************
  // unmapped addresses and refused accesses read as zero
  assign rd_mux = mc_hit[0]   ? mc_rdata[0] :
                  mc_hit[1]   ? mc_rdata[1] :
                  gate_hit[0] ? gate_rdata[0] :
                  gate_hit[1] ? gate_rdata[1] :
                  st_hit      ? {29'h0, irq_sts_q} :
                  mk_hit      ? {29'h0, irq_mask_q} :
                  32'h0000_0000;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      reg_rdata     <= 32'h0000_0000;
      reg_bus_fault <= 1'b0;
    end
    else
    begin
      reg_rdata     <= (reg_rd && reg_privileged) ? rd_mux : 32'h0000_0000;
      reg_bus_fault <= priv_fault;
    end
  end

  // ************************************************************
  // per memory: control register, gate registers, access check
  // ************************************************************
  for (genvar g = 0; g < 2; g++)
  begin : g_mem
    localparam logic [3:0]  SZ        = (g == 0) ? INSTR_MEM_SIZE : DATA_MEM_SIZE;
    localparam logic [3:0]  BS        = (g == 0) ? INSTR_BLOCK_SIZE : DATA_BLOCK_SIZE;
    localparam bit          PRES      = (g == 0) ? INSTR_GATE_PRESENT : DATA_GATE_PRESENT;
    localparam logic [31:0] A_MC      = (g == 0) ? tcg_pkg::ADDR_IMEM_CTRL : tcg_pkg::ADDR_DMEM_CTRL;
    localparam logic [31:0] A_CTRL    = (g == 0) ? tcg_pkg::ADDR_IGATE_CTRL : tcg_pkg::ADDR_DGATE_CTRL;
    localparam logic [31:0] A_CFG     = (g == 0) ? tcg_pkg::ADDR_IGATE_CFG : tcg_pkg::ADDR_DGATE_CFG;
    localparam logic [31:0] A_LUT     = (g == 0) ? tcg_pkg::ADDR_IGATE_LUT : tcg_pkg::ADDR_DGATE_LUT;
    localparam int          NB        = int'(SZ) + tcg_pkg::NUMBLK_BIAS - int'(BS);
    localparam logic [3:0]  NB4       = 4'(NB);
    localparam int          NBLK      = (NB >= tcg_pkg::LUT_IDX_W) ? tcg_pkg::LUT_BITS : (1 << NB);

    logic                         en_q;
    logic [1:0]                   ctrl_q;
    logic [tcg_pkg::LUT_BITS-1:0] lut_q;
    logic [tcg_pkg::LUT_BITS-1:0] impl_mask;
    logic [31:0]                  lut_off;
    logic [3:0]                   lut_idx;
    logic [8:0]                   lut_base;
    logic                         ctrl_hit;
    logic                         cfg_hit;
    logic                         lut_hit;
    logic                         mc_ok;
    logic                         gate_ok;
    logic                         mc_we;
    logic                         ctrl_we;
    logic                         lut_we;
    logic [31:0]                  cfg_word;
    logic [31:0]                  gate_word;
    logic [tcg_pkg::MEM_ADDR_W-1:0] addr;
    logic [8:0]                   blk_idx;
    logic                         blk_ns;
    logic                         checked;

    // implemented blocks: everything at or above the count stays zero
    for (genvar j = 0; j < tcg_pkg::LUT_BITS; j++)
    begin : g_mask
      assign impl_mask[j] = (j < NBLK);
    end

    // memory control register decode
    assign mc_hit[g] = (reg_addr == A_MC);
    assign mc_ok     = ~(SECURITY_PRESENT & ~nonsecure_fault_banking & reg_nonsecure);
    assign mc_we     = wr_ok & mc_hit[g] & mc_ok & ~lock_s[0];
    assign mc_rdata[g] = mc_ok ? {25'h0, SZ, 2'h0, en_q} : 32'h0000_0000;

    // gate register decode
    assign lut_off  = reg_addr - A_LUT;
    assign lut_idx  = lut_off[5:2];
    assign lut_base = {lut_idx, 5'h00};
    assign ctrl_hit = (reg_addr == A_CTRL);
    assign cfg_hit  = (reg_addr == A_CFG);
    assign lut_hit  = (lut_off < tcg_pkg::LUT_SPAN) & (reg_addr[1:0] == 2'h0);
    assign gate_hit[g] = ctrl_hit | cfg_hit | lut_hit;
    assign gate_ok  = ~(SECURITY_PRESENT & reg_nonsecure) & (SECURITY_PRESENT | PRES);
    assign ctrl_we  = wr_ok & ctrl_hit & gate_ok & ~lock_s[g+1];
    assign lut_we   = wr_ok & lut_hit & gate_ok & ~lock_s[g+1];

    // configuration word: presence, block count log2, block size code
    assign cfg_word = {PRES, 19'h0, NB4, 4'h0, BS};
    assign gate_word = ctrl_hit ? {30'h0, ctrl_q} :
                       cfg_hit  ? cfg_word :
                       lut_hit  ? lut_q[lut_base +: 32] :
                       32'h0000_0000;
    assign gate_rdata[g] = gate_ok ? gate_word : 32'h0000_0000;

    // enable loaded from the synchronised strap while reset is held
    always_ff @(posedge sys_clk)
    begin
      if (!rst_n)
        en_q <= init_en_s[g];
      else if (mc_we)
        en_q <= reg_wdata[tcg_pkg::MEMCR_EN_BIT];
    end

    // gate control bits
    always_ff @(posedge sys_clk)
    begin
      if (!rst_n)
        ctrl_q <= tcg_pkg::GCTRL_RST;
      else if (ctrl_we)
        ctrl_q <= reg_wdata[1:0];
    end

    // lookup words, one security bit per block
    always_ff @(posedge sys_clk)
    begin
      if (!rst_n)
        lut_q <= {16{tcg_pkg::LUT_RST}};
      else if (lut_we)
        lut_q[lut_base +: 32] <= reg_wdata & impl_mask[lut_base +: 32];
    end

    // access check: block bit against the access security state
    assign addr    = (g == 0) ? instr_acc_addr : data_acc_addr;
    assign blk_idx = 9'(addr >> (int'(BS) + tcg_pkg::BLOCK_SHIFT_BIAS));
    assign blk_ns  = lut_q[blk_idx];
    assign checked = acc_valid[g] & (acc_from_slave[g] | en_q);
    assign fault_ev[g] = PRES & checked & (blk_ns != acc_nonsecure[g]);

    // registered access results
    always_ff @(posedge sys_clk)
    begin
      if (!rst_n)
      begin
        route_to_main[g]    <= 1'b0;
        slave_port_error[g] <= 1'b0;
        data_fault[g]       <= 1'b0;
        mem_enable[g]       <= 1'b0;
      end
      else
      begin
        route_to_main[g]    <= acc_valid[g] & ~acc_from_slave[g] & ~en_q;
        slave_port_error[g] <= fault_ev[g] & acc_from_slave[g] & ctrl_q[tcg_pkg::GCTRL_SERR_BIT];
        data_fault[g]       <= fault_ev[g] & ~acc_from_slave[g] & ctrl_q[tcg_pkg::GCTRL_DFEN_BIT];
        mem_enable[g]       <= en_q;
      end
    end
  end

endmodule : tcg_top

// >>> test/tcg_cpu_model.sv
// processor software model: drives the register port
// assumes tasks are entered right after a rising edge of sys_clk
`timescale 1ns/1ns
module tcg_cpu_model (
  // clock and answers
  input  wire logic        sys_clk,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_bus_fault,
  // register requests
  output logic      [31:0] reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic             reg_privileged,
  output logic             reg_nonsecure
);
  // idle bus, secure privileged state
  initial
  begin
    reg_addr       = 32'h0000_0000;
    reg_wdata      = 32'h0000_0000;
    reg_wr         = 1'b0;
    reg_rd         = 1'b0;
    reg_privileged = 1'b1;
    reg_nonsecure  = 1'b0;
  end
  // privilege and security state of later requests
  task automatic mode(input logic p, input logic n);
    reg_privileged <= p;
    reg_nonsecure  <= n;
  endtask : mode
  // one-cycle write, address scrambled once released
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
    @(posedge sys_clk);
  endtask : wr
  // one-cycle read, data and fault taken in the following cycle
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic f);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(posedge sys_clk);
    d = reg_rdata;
    f = reg_bus_fault;
  endtask : rd
endmodule : tcg_cpu_model

// >>> test/tcg_props.sv
// checker for the memory control and security gate block
// assumes the top module's ports and one clock with synchronous reset
`timescale 1ns/1ns
module tcg_props #(
  parameter logic [3:0] INSTR_MEM_SIZE   = 4'h6,
  parameter logic [3:0] INSTR_BLOCK_SIZE = 4'h3
) (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // register port
  input wire logic [31:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic        reg_privileged,
  input wire logic        reg_nonsecure,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_bus_fault,
  input wire logic        nonsecure_fault_banking,
  // memory accesses
  input wire logic [1:0]  acc_valid,
  input wire logic [1:0]  acc_from_slave,
  input wire logic [1:0]  route_to_main,
  input wire logic [1:0]  slave_port_error,
  input wire logic [1:0]  data_fault
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ************************************************************
  // register reads
  // ************************************************************
  sequence s_rd(logic [31:0] a);
    reg_rd && reg_privileged && !reg_nonsecure && reg_addr == a;
  endsequence
  sequence s_ns_rd(logic [31:0] a);
    reg_rd && reg_privileged && reg_nonsecure && reg_addr == a;
  endsequence
  AST_MEM_SIZE: assert property (s_rd(tcg_pkg::ADDR_IMEM_CTRL) |=> reg_rdata[6:3] == INSTR_MEM_SIZE)
    else $error("memory size field wrong");
  AST_GATE_CFG: assert property (s_rd(tcg_pkg::ADDR_IGATE_CFG) |=>
    reg_rdata == {1'b1, 19'h0, INSTR_MEM_SIZE + 4'h4 - INSTR_BLOCK_SIZE, 4'h0, INSTR_BLOCK_SIZE})
    else $error("gate config value wrong");
  AST_MEM_NS: assert property (s_ns_rd(tcg_pkg::ADDR_DMEM_CTRL) ##0 !nonsecure_fault_banking |=> reg_rdata == 32'h0)
    else $error("memory control visible from non-secure");
  AST_GATE_NS: assert property (s_ns_rd(tcg_pkg::ADDR_DGATE_CTRL) |=> reg_rdata == 32'h0 && !reg_bus_fault)
    else $error("gate control visible from non-secure");
  AST_UNPRIV: assert property ((reg_rd || reg_wr) && !reg_privileged && reg_addr == tcg_pkg::ADDR_IGATE_CTRL |=>
    reg_bus_fault && reg_rdata == 32'h0)
    else $error("unprivileged access not refused");
  AST_PRIV_OK: assert property ((reg_rd || reg_wr) && reg_privileged |=> !reg_bus_fault)
    else $error("bus fault on privileged access");
  // ************************************************************
  // memory accesses
  // ************************************************************
  AST_ROUTE: assert property (route_to_main[1] |-> $past(acc_valid[1]) && !$past(acc_from_slave[1]))
    else $error("route without software access");
  AST_SLAVE_NOROUTE: assert property (acc_valid[1] && acc_from_slave[1] |=> !route_to_main[1])
    else $error("slave access routed away");
  AST_SERR_SRC: assert property (slave_port_error[1] |-> $past(acc_valid[1]) && $past(acc_from_slave[1]))
    else $error("slave error without slave access");
  AST_DFLT_SRC: assert property (data_fault[0] |-> $past(acc_valid[0]) && !$past(acc_from_slave[0]))
    else $error("data fault without software access");
endmodule : tcg_props
bind tcg_top tcg_props #(.INSTR_MEM_SIZE(INSTR_MEM_SIZE), .INSTR_BLOCK_SIZE(INSTR_BLOCK_SIZE)) i_props (
  .sys_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_privileged, .reg_nonsecure, .reg_rdata,
  .reg_bus_fault, .nonsecure_fault_banking, .acc_valid, .acc_from_slave, .route_to_main,
  .slave_port_error, .data_fault);

// >>> test/test_tcg_top.sv
// self-checking bench for the memory control and security gate block
// assumes default parameters: size code 6, block code 3, both gates present
`timescale 1ns/1ns
module test_tcg_top;
  logic        sys_clk, rst_n, reg_wr, reg_rd, reg_privileged, reg_nonsecure, reg_bus_fault, irq, f;
  logic        mem_ctrl_lock_in, instr_gate_lock_in, data_gate_lock_in, nonsecure_fault_banking;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [1:0]  initial_mem_enable_in, acc_valid, acc_from_slave, acc_nonsecure, route_to_main;
  logic [1:0]  slave_port_error, data_fault, mem_enable;
  logic [23:0] instr_acc_addr, data_acc_addr;
  logic [2:0]  r;
  int          errors, compares, cycles;
  tcg_top i_dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_privileged, .reg_nonsecure,
    .reg_rdata, .reg_bus_fault, .initial_mem_enable_in, .mem_ctrl_lock_in, .instr_gate_lock_in,
    .data_gate_lock_in, .nonsecure_fault_banking, .acc_valid, .acc_from_slave, .acc_nonsecure,
    .instr_acc_addr, .data_acc_addr, .route_to_main, .slave_port_error, .data_fault, .mem_enable, .irq);
  tcg_cpu_model i_cpu (.sys_clk, .reg_rdata, .reg_bus_fault, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_privileged, .reg_nonsecure);
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin errors++; $display("mismatch %s expected %h seen %h", n, e, g); end
  endtask : chk
  task automatic test_done;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // one memory access, result is route, slave error, data fault
  task automatic acc(input int g, input logic s, input logic n, input logic [23:0] a);
    acc_valid[g] <= 1'b1;
    acc_from_slave[g] <= s;
    acc_nonsecure[g] <= n;
    instr_acc_addr <= a;
    data_acc_addr <= a;
    @(posedge sys_clk);
    acc_valid[g] <= 1'b0;
    @(posedge sys_clk);
    r = {route_to_main[g], slave_port_error[g], data_fault[g]};
  endtask : acc
  task automatic rchk(input string n, input logic [31:0] a, input logic [31:0] e);
    i_cpu.rd(a, d, f);
    chk(n, e, d);
  endtask : rchk
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    chk("mem enable", 32'h1, {30'h0, mem_enable});
    rchk("imem ctrl", tcg_pkg::ADDR_IMEM_CTRL, 32'h0000_0031);
    rchk("dmem ctrl", tcg_pkg::ADDR_DMEM_CTRL, 32'h0000_0030);
    rchk("igate ctrl", tcg_pkg::ADDR_IGATE_CTRL, 32'h0000_0003);
    rchk("dgate cfg", tcg_pkg::ADDR_DGATE_CFG, 32'h8000_0703);
    rchk("igate cfg", tcg_pkg::ADDR_IGATE_CFG, 32'h8000_0703);
    $display("test reset done");
  endtask : t_reset
  task automatic t_lookup;
    i_cpu.wr(tcg_pkg::ADDR_IGATE_LUT + 32'h0000_000C, 32'hFFFF_FFFF);
    i_cpu.wr(tcg_pkg::ADDR_IGATE_LUT + 32'h0000_0010, 32'hFFFF_FFFF);
    rchk("lut 3", tcg_pkg::ADDR_IGATE_LUT + 32'h0000_000C, 32'hFFFF_FFFF);
    rchk("lut 4", tcg_pkg::ADDR_IGATE_LUT + 32'h0000_0010, 32'h0000_0000);
    instr_gate_lock_in <= 1'b1;
    repeat (3) @(posedge sys_clk);
    i_cpu.wr(tcg_pkg::ADDR_IGATE_LUT + 32'h0000_000C, 32'h0000_0000);
    i_cpu.wr(tcg_pkg::ADDR_IGATE_CTRL, 32'h0000_0000);
    rchk("locked lut", tcg_pkg::ADDR_IGATE_LUT + 32'h0000_000C, 32'hFFFF_FFFF);
    rchk("locked ctrl", tcg_pkg::ADDR_IGATE_CTRL, 32'h0000_0003);
    $display("test lookup done");
  endtask : t_lookup
  task automatic t_access_rights;
    mem_ctrl_lock_in <= 1'b1;
    repeat (3) @(posedge sys_clk);
    i_cpu.wr(tcg_pkg::ADDR_IMEM_CTRL, 32'h0000_0000);
    rchk("locked memcr", tcg_pkg::ADDR_IMEM_CTRL, 32'h0000_0031);
    i_cpu.mode(1'b1, 1'b1);
    rchk("ns dgate ctrl", tcg_pkg::ADDR_DGATE_CTRL, 32'h0000_0000);
    rchk("ns memcr", tcg_pkg::ADDR_DMEM_CTRL, 32'h0000_0000);
    nonsecure_fault_banking <= 1'b1;
    rchk("banked memcr", tcg_pkg::ADDR_DMEM_CTRL, 32'h0000_0030);
    i_cpu.mode(1'b0, 1'b0);
    i_cpu.rd(tcg_pkg::ADDR_IGATE_CTRL, d, f);
    chk("unpriv fault", 32'h1, {31'h0, f});
    i_cpu.mode(1'b1, 1'b0);
    rchk("irq status", tcg_pkg::ADDR_IRQ_STATUS, 32'h0000_0004);
    $display("test access rights done");
  endtask : t_access_rights
  task automatic t_gate;
    i_cpu.wr(tcg_pkg::ADDR_IRQ_STATUS, 32'h0000_0007);
    i_cpu.wr(tcg_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    i_cpu.wr(tcg_pkg::ADDR_DGATE_LUT, 32'h0000_0001);
    acc(1, 1'b0, 1'b0, 24'h00_0000);
    chk("sw disabled", 32'h4, {29'h0, r});
    acc(1, 1'b1, 1'b0, 24'h00_0000);
    chk("slave mismatch", 32'h2, {29'h0, r});
    acc(1, 1'b1, 1'b1, 24'h00_00FF);
    chk("slave match", 32'h0, {29'h0, r});
    chk("irq masked", 32'h0, {31'h0, irq});
    i_cpu.wr(tcg_pkg::ADDR_DGATE_CTRL, 32'h0000_0001);
    acc(1, 1'b1, 1'b0, 24'h00_0000);
    chk("error off", 32'h0, {29'h0, r});
    acc(0, 1'b0, 1'b1, 24'h00_0100);
    chk("sw mismatch", 32'h1, {29'h0, r});
    @(posedge sys_clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    rchk("irq status", tcg_pkg::ADDR_IRQ_STATUS, 32'h0000_0003);
    i_cpu.wr(tcg_pkg::ADDR_IRQ_STATUS, 32'h0000_0007);
    @(posedge sys_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test gate done");
  endtask : t_gate
  // ************************************************************
  // clock, watchdog and main sequence
  // ************************************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000) begin errors++; test_done(); end
  end
  initial
  begin
    {rst_n, mem_ctrl_lock_in, instr_gate_lock_in, data_gate_lock_in, nonsecure_fault_banking} = 5'h00;
    {acc_valid, acc_from_slave, acc_nonsecure, instr_acc_addr, data_acc_addr} = 54'h0;
    initial_mem_enable_in = 2'h1;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    // the first edge after release launches mem_enable, so look one edge later
    @(posedge sys_clk);
    @(posedge sys_clk);
    t_reset();
    t_lookup();
    t_access_rights();
    t_gate();
    test_done();
  end
endmodule : test_tcg_top
